// ---- hdl/dhm_pkg.sv ----
// Shared constants and types for the dual channel host port block.
package dhm_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  // Register offsets within one channel.
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_FCR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SPR = 3'h7;
  // Field positions.
  localparam int LCR_DLAB = 7;
  localparam int MCR_PRESCALE = 7;
  localparam int MCR_LOOP = 4;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int DLD_OSR_LO = 4;
  localparam int LSR_DR = 0;
  localparam int LSR_OE = 1;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  // Reset values.
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [6:0] MCR_LOW_RST = 7'h00;
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLM_RST = 8'h00;
  localparam logic [7:0] DLD_RST = 8'h00;
  localparam logic [7:0] SPR_RST = 8'hff;
  // Interrupt identification codes.
  localparam logic [7:0] ISR_NONE = 8'h01;
  localparam logic [7:0] ISR_TX = 8'h02;
  localparam logic [7:0] ISR_RX = 8'h04;
  // Oversampling codes and the matching last sample index.
  localparam logic [1:0] OSR_8 = 2'h1;
  localparam logic [1:0] OSR_4 = 2'h2;
  localparam logic [4:0] OSR16_LAST = 5'h0f;
  localparam logic [4:0] OSR8_LAST = 5'h07;
  localparam logic [4:0] OSR4_LAST = 5'h03;
  localparam logic [1:0] PRE_DIV4_LAST = 2'h3;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  localparam logic [2:0] RX_LAST_BIT = 3'h7;
  localparam logic [1:0] BOOT_CYC = 2'h3;

  typedef struct packed {
    logic mode_strap;
    logic prescaler_strap;
    logic reset_pin;
    logic read_strobe_n;
    logic write_strobe_n;
    logic chan_a_select_n;
    logic chan_b_select_n;
    logic rw_dir;
    logic chip_select_n;
    logic channel_addr_bit;
    logic [2:0] addr;
    logic [7:0] data;
    logic rx_a;
    logic rx_b;
  } dhm_pins_t;

  localparam dhm_pins_t PINS_IDLE = '1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] data;
  } dhm_req_t;

  typedef enum logic {TX_IDLE, TX_SHIFT} dhm_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dhm_rx_t;
endpackage

// ---- hdl/dhm_host_port.sv ----
// Dual channel serial controller with strap selected host bus and reset front end.
// Overview of operation
// R1 - Bus strap high: separate read and write strobes, one select per channel.
// R2 - Bus strap low: direction line, single select, channel address bit.
// R3 - Prescaler strap is sampled only during reset; later changes are ignored.
// R4 - Strap high divides baud input clock by 1, low divides by 4.
// R5 - Software writing the prescaler control bit overrides the strap choice.
// R6 - Reset pin is active high in strobe style, active low in direction style.
// R7 - A reset of at least 40 ns resets registers and outputs of both channels.
// R8 - During reset transmit outputs stay high and receive inputs are ignored.
// R9 - Host in strobe style uses low read, low write and low channel selects.
// R10 - Host in direction style uses direction line, low select, address bit.
// R11 - One shared host port; each channel has its own full register set.
// R12 - Each channel has 32 byte transmit and receive FIFOs.
// R13 - Oversampling is selectable as 16, 8 or 4 samples per bit.
// R14 - After reset registers behave as the classic legacy serial controller.
// R15 - Direction style: address bit 0 picks channel A, 1 picks channel B.
// R16 - Strobe style: low select picks a channel; both may be written together.
// R17 - Host cycles are timed by the bus strobes only, not the serial clock; the code samples every strobe on clk, which also clocks the baud divider.
// R18 - Strap choice is loaded into each prescaler control bit at reset release.
`timescale 1ns/100ps
`default_nettype none

module dhm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  always_ff @(posedge clk) if (push) mem[wr_ptr_reg[AW-1:0]] <= in_data;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + (AW + 1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW + 1)'(pop);
    end
  end
endmodule // dhm_fifo

module dhm_channel (
  // Clock and resets.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chan_rst,
  input wire logic strap_div1,
  // Host request.
  input wire dhm_pkg::dhm_req_t req,
  output logic [7:0] rdata,
  // Serial pins.
  input wire logic rx_in,
  output logic tx_out
);
  logic [7:0] ier_reg, fcr_reg, lcr_reg, mcr_reg, dll_reg, dlm_reg, dld_reg, spr_reg;
  logic ovr_reg;
  logic [1:0] pre_reg;
  logic [15:0] div_reg;
  logic [4:0] tsmp_reg, rsmp_reg;
  logic [3:0] tbit_reg;
  logic [2:0] rbit_reg;
  logic [9:0] tsh_reg;
  logic [7:0] rsh_reg;
  logic tline_reg;
  dhm_pkg::dhm_tx_t tst_reg;
  dhm_pkg::dhm_rx_t rst_reg;
  wire dlab = lcr_reg[dhm_pkg::LCR_DLAB];
  wire loop = mcr_reg[dhm_pkg::MCR_LOOP];
  wire wr_data = req.wr && req.addr == dhm_pkg::ADDR_DATA && !dlab;
  wire rd_data = req.rd && req.addr == dhm_pkg::ADDR_DATA && !dlab;
  wire wr_fcr = req.wr && req.addr == dhm_pkg::ADDR_FCR && !dlab;
  wire rd_lsr = req.rd && req.addr == dhm_pkg::ADDR_LSR;
  wire [1:0] pre_last = mcr_reg[dhm_pkg::MCR_PRESCALE] ? dhm_pkg::PRE_DIV4_LAST : 2'h0; // R4 R5
  wire [1:0] osr = dld_reg[dhm_pkg::DLD_OSR_LO +: 2];
  wire [4:0] osr_last = osr == dhm_pkg::OSR_8 ? dhm_pkg::OSR8_LAST :
    osr == dhm_pkg::OSR_4 ? dhm_pkg::OSR4_LAST : dhm_pkg::OSR16_LAST; // R13
  wire [15:0] divisor = {dlm_reg, dll_reg};
  wire pre_tick = pre_reg == pre_last;
  wire tick = pre_tick && divisor != 16'h0000 && div_reg == divisor - 16'h0001;
  wire tx_in_ready, tx_valid, rx_in_ready, rx_valid;
  wire [7:0] tx_data, rx_data;
  wire rx_line = loop ? tline_reg : rx_in;
  // A frame starts only on a sample tick, so the start bit lasts a full bit time. R13
  wire tx_take = tst_reg == dhm_pkg::TX_IDLE && tx_valid && tick;
  wire rx_push = rst_reg == dhm_pkg::RX_STOP && tick && rsmp_reg == osr_last && rx_line;
  wire [7:0] lsr = {1'b0, tx_take || (!tx_valid && tst_reg == dhm_pkg::TX_IDLE), 
    !tx_valid, 3'h0, ovr_reg, rx_valid};
  wire [7:0] isr = (ier_reg[0] && rx_valid) ? dhm_pkg::ISR_RX :
    (ier_reg[1] && !tx_valid) ? dhm_pkg::ISR_TX : dhm_pkg::ISR_NONE;

  // Each channel keeps its own FIFO pair and register set. R11 R12
  dhm_fifo #(.WIDTH(dhm_pkg::DATA_W), .DEPTH(dhm_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk(clk), .rst_n(rst_n), .flush(chan_rst || (wr_fcr && req.data[dhm_pkg::FCR_TXRST])),
    .in_valid(wr_data), .in_ready(tx_in_ready), .in_data(req.data),
    .out_valid(tx_valid), .out_ready(tx_take), .out_data(tx_data)
  );
  dhm_fifo #(.WIDTH(dhm_pkg::DATA_W), .DEPTH(dhm_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk(clk), .rst_n(rst_n), .flush(chan_rst || (wr_fcr && req.data[dhm_pkg::FCR_RXRST])),
    .in_valid(rx_push), .in_ready(rx_in_ready), .in_data(rsh_reg),
    .out_valid(rx_valid), .out_ready(rd_data), .out_data(rx_data)
  );

  always_comb
  begin
    case (req.addr)
      dhm_pkg::ADDR_DATA: rdata = dlab ? dll_reg : rx_data;
      dhm_pkg::ADDR_IER: rdata = dlab ? dlm_reg : ier_reg;
      dhm_pkg::ADDR_FCR: rdata = dlab ? dld_reg : isr;
      dhm_pkg::ADDR_LCR: rdata = lcr_reg;
      dhm_pkg::ADDR_MCR: rdata = mcr_reg;
      dhm_pkg::ADDR_LSR: rdata = lsr;
      dhm_pkg::ADDR_SPR: rdata = spr_reg;
      default: rdata = 8'h00;
    endcase
  end

  // Register file; a channel reset restores legacy defaults and loads the strap. R14 R18
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {ier_reg, fcr_reg, lcr_reg} <= {dhm_pkg::IER_RST, dhm_pkg::FCR_RST, dhm_pkg::LCR_RST};
      {dll_reg, dlm_reg, dld_reg} <= {dhm_pkg::DLL_RST, dhm_pkg::DLM_RST, dhm_pkg::DLD_RST};
      mcr_reg <= {1'b0, dhm_pkg::MCR_LOW_RST};
      spr_reg <= dhm_pkg::SPR_RST;
      ovr_reg <= 1'b0;
    end
    else if (chan_rst)
    begin
      {ier_reg, fcr_reg, lcr_reg} <= {dhm_pkg::IER_RST, dhm_pkg::FCR_RST, dhm_pkg::LCR_RST};
      {dll_reg, dlm_reg, dld_reg} <= {dhm_pkg::DLL_RST, dhm_pkg::DLM_RST, dhm_pkg::DLD_RST};
      mcr_reg <= {!strap_div1, dhm_pkg::MCR_LOW_RST}; // R18 R7
      spr_reg <= dhm_pkg::SPR_RST;
      ovr_reg <= 1'b0;
    end
    else
    begin
      if (req.wr)
      begin
        case (req.addr)
          dhm_pkg::ADDR_DATA: if (dlab) dll_reg <= req.data;
          dhm_pkg::ADDR_IER: if (dlab) dlm_reg <= req.data; else ier_reg <= req.data;
          dhm_pkg::ADDR_FCR: if (dlab) dld_reg <= req.data; else fcr_reg <= req.data;
          dhm_pkg::ADDR_LCR: lcr_reg <= req.data;
          dhm_pkg::ADDR_MCR: mcr_reg <= req.data; // R5
          dhm_pkg::ADDR_SPR: spr_reg <= req.data;
          default: spr_reg <= spr_reg;
        endcase
      end
      // A new overrun in the cycle of the status read keeps the flag set.
      ovr_reg <= (rx_push && !rx_in_ready) || (ovr_reg && !rd_lsr);
    end
  end

  // Baud sample tick: prescaler, then divisor.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg <= 2'h0;
      div_reg <= 16'h0000;
    end
    else
    begin
      pre_reg <= (pre_tick || chan_rst) ? 2'h0 : pre_reg + 2'h1; // R4
      if (chan_rst || tick)
        div_reg <= 16'h0000;
      else if (pre_tick)
        div_reg <= div_reg + 16'h0001;
    end
  end

  // Transmitter, 8 data bits with one stop bit; it stalls while its FIFO is empty.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tst_reg <= dhm_pkg::TX_IDLE;
      tsh_reg <= '1;
      tsmp_reg <= 5'h00;
      tbit_reg <= 4'h0;
      tline_reg <= 1'b1;
      tx_out <= 1'b1;
    end
    else if (chan_rst)
    begin
      tst_reg <= dhm_pkg::TX_IDLE;
      tsh_reg <= '1;
      tline_reg <= 1'b1;
      tx_out <= 1'b1; // R8
    end
    else
    begin
      tline_reg <= tst_reg == dhm_pkg::TX_SHIFT ? tsh_reg[0] : 1'b1;
      tx_out <= loop ? 1'b1 : tline_reg;
      case (tst_reg)
        dhm_pkg::TX_IDLE:
          if (tx_take)
          begin
            tsh_reg <= {1'b1, tx_data, 1'b0};
            tsmp_reg <= 5'h00;
            tbit_reg <= 4'h0;
            tst_reg <= dhm_pkg::TX_SHIFT;
          end
        dhm_pkg::TX_SHIFT:
          if (tick)
          begin
            tsmp_reg <= tsmp_reg == osr_last ? 5'h00 : tsmp_reg + 5'h01; // R13
            if (tsmp_reg == osr_last)
            begin
              tsh_reg <= {1'b1, tsh_reg[9:1]};
              tbit_reg <= tbit_reg + 4'h1;
              if (tbit_reg == dhm_pkg::TX_LAST_BIT)
                tst_reg <= dhm_pkg::TX_IDLE;
            end
          end
        default: tst_reg <= dhm_pkg::TX_IDLE;
      endcase
    end
  end

  // Receiver; held idle during reset so the line is ignored.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_reg <= dhm_pkg::RX_IDLE;
      rsmp_reg <= 5'h00;
      rbit_reg <= 3'h0;
      rsh_reg <= 8'h00;
    end
    else if (chan_rst)
      rst_reg <= dhm_pkg::RX_IDLE; // R8
    else
    begin
      if (tick && rst_reg != dhm_pkg::RX_IDLE)
        rsmp_reg <= rsmp_reg == osr_last ? 5'h00 : rsmp_reg + 5'h01;
      case (rst_reg)
        dhm_pkg::RX_IDLE:
          if (!rx_line)
          begin
            rst_reg <= dhm_pkg::RX_START;
            rsmp_reg <= 5'h00;
          end
        dhm_pkg::RX_START:
          if (tick && rsmp_reg == {1'b0, osr_last[4:1]})
          begin
            rst_reg <= rx_line ? dhm_pkg::RX_IDLE : dhm_pkg::RX_DATA;
            rsmp_reg <= 5'h00;
            rbit_reg <= 3'h0;
          end
        dhm_pkg::RX_DATA:
          if (tick && rsmp_reg == osr_last)
          begin
            rsh_reg <= {rx_line, rsh_reg[7:1]};
            rbit_reg <= rbit_reg + 3'h1;
            if (rbit_reg == dhm_pkg::RX_LAST_BIT)
              rst_reg <= dhm_pkg::RX_STOP;
          end
        dhm_pkg::RX_STOP:
          if (tick && rsmp_reg == osr_last)
            rst_reg <= dhm_pkg::RX_IDLE;
        default: rst_reg <= dhm_pkg::RX_IDLE;
      endcase
    end
  end
endmodule // dhm_channel

module dhm_host_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Straps and reset pin.
  input wire logic mode_strap,
  input wire logic prescaler_strap,
  input wire logic reset_pin,
  // Strobe style host pins.
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  // Direction style host pins.
  input wire logic rw_dir,
  input wire logic chip_select_n,
  input wire logic channel_addr_bit,
  // Shared address and data.
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Serial pins.
  input wire logic rx_a,
  input wire logic rx_b,
  output logic tx_a,
  output logic tx_b
);
  dhm_pkg::dhm_pins_t meta_reg, pin_reg;
  dhm_pkg::dhm_req_t hold_reg;
  logic [1:0] hsel_reg;
  logic act_reg;
  logic strap_div1_reg;
  logic [1:0] boot_reg;
  wire [7:0] rdata_a, rdata_b;

  // Host strobes are asynchronous to clk, so every pin is synchronised first. R17
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= dhm_pkg::PINS_IDLE;
      pin_reg <= dhm_pkg::PINS_IDLE;
    end
    else
    begin
      meta_reg <= {mode_strap, prescaler_strap, reset_pin, read_strobe_n, write_strobe_n,
        chan_a_select_n, chan_b_select_n, rw_dir, chip_select_n, channel_addr_bit,
        addr, data_in, rx_a, rx_b};
      pin_reg <= meta_reg;
    end
  end

  wire strobe_mode = pin_reg.mode_strap;
  wire pin_rst = strobe_mode ? pin_reg.reset_pin : !pin_reg.reset_pin; // R6
  wire chan_rst = pin_rst || boot_reg != 2'h0; // R7
  wire rd_now = strobe_mode ? !pin_reg.read_strobe_n :
    !pin_reg.chip_select_n && pin_reg.rw_dir; // R1 R2 R9 R10
  wire wr_now = strobe_mode ? !pin_reg.write_strobe_n :
    !pin_reg.chip_select_n && !pin_reg.rw_dir;
  wire [1:0] sel_now = strobe_mode ? {!pin_reg.chan_b_select_n, !pin_reg.chan_a_select_n} :
    {pin_reg.channel_addr_bit, !pin_reg.channel_addr_bit}; // R15 R16
  wire act_now = (rd_now || wr_now) && sel_now != 2'b00 && !chan_rst;
  wire fin = act_reg && !act_now;
  wire dhm_pkg::dhm_req_t req_a = '{wr: fin && hold_reg.wr && hsel_reg[0],
    rd: fin && hold_reg.rd && hsel_reg[0], addr: hold_reg.addr, data: hold_reg.data};
  wire dhm_pkg::dhm_req_t req_b = '{wr: fin && hold_reg.wr && hsel_reg[1],
    rd: fin && hold_reg.rd && hsel_reg[1], addr: hold_reg.addr, data: hold_reg.data};

  // The access is latched while the strobe is active and acted on as it ends.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_reg <= 1'b0;
      hold_reg <= '0;
      hsel_reg <= 2'b00;
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end
    else
    begin
      act_reg <= act_now;
      if (act_now)
      begin
        hold_reg <= '{wr: wr_now, rd: rd_now, addr: pin_reg.addr, data: pin_reg.data};
        hsel_reg <= sel_now;
      end
      // Channel A wins if both are read; the host must not do that. R16
      data_out <= hsel_reg[0] ? rdata_a : rdata_b;
      data_oe <= act_now && rd_now;
    end
  end

  // Prescaler strap is taken only while reset is in force. R3
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_reg <= dhm_pkg::BOOT_CYC;
      strap_div1_reg <= 1'b1;
    end
    else
    begin
      boot_reg <= boot_reg == 2'h0 ? 2'h0 : boot_reg - 2'h1;
      if (chan_rst)
        strap_div1_reg <= pin_reg.prescaler_strap; // R3 R4
    end
  end

  // The live strap feeds the channels during reset, so the last reset cycle loads it. R18
  wire strap_now = chan_rst ? pin_reg.prescaler_strap : strap_div1_reg;
  dhm_channel u_chan_a (
    .clk(clk), .rst_n(rst_n), .chan_rst(chan_rst), .strap_div1(strap_now),
    .req(req_a), .rdata(rdata_a), .rx_in(pin_reg.rx_a), .tx_out(tx_a)
  );
  dhm_channel u_chan_b (
    .clk(clk), .rst_n(rst_n), .chan_rst(chan_rst), .strap_div1(strap_now),
    .req(req_b), .rdata(rdata_b), .rx_in(pin_reg.rx_b), .tx_out(tx_b)
  );
endmodule // dhm_host_port

`default_nettype wire

// ---- tb/dhm_host_port_asserts.sv ----
// Pin level checks for the dual channel host port.
`timescale 1ns/100ps
`default_nettype none
module dhm_host_port_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Straps and host pins.
  input wire logic mode_strap,
  input wire logic reset_pin,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic rw_dir,
  input wire logic chip_select_n,
  // Watched outputs.
  input wire logic data_oe,
  input wire logic tx_a,
  input wire logic tx_b
);
  // Decodes use the raw pins, so every check leaves room for the two sync flops.
  wire logic sel;
  wire logic rd;
  wire logic wr;
  wire logic prst;
  assign sel = !(chan_a_select_n && chan_b_select_n);
  assign rd = mode_strap ? !read_strobe_n && sel : rw_dir && !chip_select_n;
  assign wr = mode_strap ? !write_strobe_n && sel : !rw_dir && !chip_select_n;
  assign prst = mode_strap ? reset_pin : !reset_pin;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_boot_quiet: assert property ($rose(rst_n) |-> tx_a && tx_b && !data_oe)
    else $error("outputs not idle after reset");
  a_strobe_reset: assert property ((mode_strap && reset_pin) [*6] |-> tx_a && tx_b)
    else $error("high reset pin did not idle the lines");
  a_dir_reset: assert property ((!mode_strap && !reset_pin) [*6] |-> tx_a && tx_b)
    else $error("low reset pin did not idle the lines");
  a_oe_cause: assert property ($rose(data_oe) |-> $past(rd, 2))
    else $error("data driven without a read");
  a_oe_read: assert property ((rd && !prst) [*5] |-> data_oe)
    else $error("read not answered");
  a_oe_idle: assert property ((!rd) [*5] |-> !data_oe)
    else $error("data driven while idle");
  a_write_quiet: assert property (wr [*5] |-> !data_oe)
    else $error("data driven during a write");
  a_oe_end: assert property ($fell(rd) && data_oe |-> data_oe [*2] ##[1:2] !data_oe)
    else $error("data release off the strobe");
endmodule // dhm_host_port_asserts
bind dhm_host_port dhm_host_port_asserts dhm_host_port_asserts_i (
  .clk(clk), .rst_n(rst_n), .mode_strap(mode_strap), .reset_pin(reset_pin),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
  .rw_dir(rw_dir), .chip_select_n(chip_select_n), .data_oe(data_oe),
  .tx_a(tx_a), .tx_b(tx_b));
`default_nettype wire

// ---- tb/dhm_host_model.sv ----
// Host processor model that drives either bus style.
`timescale 1ns/100ps
`default_nettype none
module dhm_host_model (
  // Clock and bus style.
  input wire logic clk,
  input wire logic mode_strap,
  // Strobe style pins.
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  // Direction style pins.
  output logic rw_dir,
  output logic chip_select_n,
  output logic channel_addr_bit,
  // Shared address and data.
  output logic [2:0] addr,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out
);
  initial
  begin
    {read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n} = 4'hf;
    {rw_dir, chip_select_n, channel_addr_bit} = 3'h6;
    addr = 3'h0;
    data_in = 8'h00;
  end
  // Data is inverted when not written, so a stale byte never looks valid.
  task automatic acc(input logic w, input logic [1:0] ch, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
    repeat (5) @(posedge clk);
    addr <= a;
    data_in <= w ? d : ~data_in;
    if (mode_strap)
    begin
      read_strobe_n <= w;
      write_strobe_n <= !w;
      chan_a_select_n <= !ch[0];
      chan_b_select_n <= !ch[1];
    end
    else
    begin
      rw_dir <= !w;
      chip_select_n <= 1'b0;
      channel_addr_bit <= ch[1];
    end
    repeat (6) @(posedge clk);
    q = data_out;
    {read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n} <= 4'hf;
    {rw_dir, chip_select_n} <= 2'h3;
    data_in <= ~data_in;
  endtask
endmodule // dhm_host_model
`default_nettype wire

// ---- tb/tb_dhm_host_port.sv ----
// Self-checking bench for the dual channel host port.
`timescale 1ns/100ps
`default_nettype none
module tb_dhm_host_port;
  typedef struct packed {
    logic [7:0] dld;
    logic [7:0] modem_control_reg;
    logic [15:0] cyc;
  } dhm_row_t;
  dhm_row_t rows [5] = '{'{8'h00, 8'h00, 16'h0010}, '{8'h10, 8'h00, 16'h0008},
    '{8'h20, 8'h00, 16'h0004}, '{8'h30, 8'h00, 16'h0010}, '{8'h20, 8'h80, 16'h0010}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_strap = 1'b1;
  logic prescaler_strap = 1'b1;
  logic reset_pin = 1'b0;
  wire logic read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n;
  wire logic rw_dir, chip_select_n, channel_addr_bit, data_oe, tx_a, tx_b;
  wire logic [2:0] addr;
  wire logic [7:0] data_in, data_out;
  int bad_count = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  // The serial lines are crossed, so each channel hears the other.
  dhm_host_port dhm_host_port_i (.clk(clk), .rst_n(rst_n), .mode_strap(mode_strap),
    .prescaler_strap(prescaler_strap), .reset_pin(reset_pin), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .chan_a_select_n(chan_a_select_n),
    .chan_b_select_n(chan_b_select_n), .rw_dir(rw_dir), .chip_select_n(chip_select_n),
    .channel_addr_bit(channel_addr_bit), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rx_a(tx_b), .rx_b(tx_a), .tx_a(tx_a), .tx_b(tx_b));
  dhm_host_model dhm_host_model_i (.clk(clk), .mode_strap(mode_strap),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n), .rw_dir(rw_dir),
    .chip_select_n(chip_select_n), .channel_addr_bit(channel_addr_bit), .addr(addr),
    .data_in(data_in), .data_out(data_out));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    dhm_host_model_i.acc(1'b1, ch, a, d, q);
  endtask
  task automatic rd(input logic [1:0] ch, input logic [2:0] a, output logic [15:0] q);
    logic [7:0] r;
    dhm_host_model_i.acc(1'b0, ch, a, 8'h00, r);
    q = {8'h00, r};
  endtask
  task automatic cfg(input logic [7:0] dld);
    wr(2'b11, dhm_pkg::ADDR_LCR, 8'h80);
    wr(2'b11, dhm_pkg::ADDR_FCR, dld);
    wr(2'b11, dhm_pkg::ADDR_LCR, 8'h03);
  endtask
  task automatic rx_get(input logic [7:0] exp);
    logic [15:0] q;
    int k;
    q = 16'h0000;
    k = 0;
    while (q[dhm_pkg::LSR_DR] !== 1'b1 && k < 80)
    begin
      rd(2'b10, dhm_pkg::ADDR_LSR, q);
      k++;
    end
    rd(2'b10, dhm_pkg::ADDR_DATA, q);
    check("byte on channel b", q, {8'h00, exp});
  endtask
  // A zero byte keeps the line low for the start bit and all eight data bits.
  task automatic send_zero(input logic [15:0] cyc);
    logic [15:0] n;
    n = 16'h0000;
    wr(2'b01, dhm_pkg::ADDR_DATA, 8'h00);
    while (tx_a !== 1'b0 && n < 16'h0fa0)
    begin
      @(negedge clk);
      n++;
    end
    n = 16'h0000;
    while (tx_a === 1'b0 && n < 16'h0fa0)
    begin
      @(negedge clk);
      n++;
    end
    check("low run", n, cyc * 16'h0009);
    rx_get(8'h00);
  endtask
  task automatic pulse(input logic v);
    reset_pin <= v;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check("idle pins", {13'h0000, tx_a, tx_b, data_oe}, 16'h0006);
    @(posedge clk);
    reset_pin <= !v;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    logic [15:0] q;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i])
    begin
      cfg(rows[i].dld);
      wr(2'b11, dhm_pkg::ADDR_MCR, rows[i].modem_control_reg);
      rd(2'b01, dhm_pkg::ADDR_MCR, q);
      check("mcr", q, {8'h00, rows[i].modem_control_reg});
      send_zero(rows[i].cyc);
    end
    $display("rate rows done");
    pulse(1'b1);
    rd(2'b01, dhm_pkg::ADDR_SPR, q);
    check("spr", q, {8'h00, dhm_pkg::SPR_RST});
    rd(2'b01, dhm_pkg::ADDR_LCR, q);
    check("lcr", q, {8'h00, dhm_pkg::LCR_RST});
    rd(2'b01, dhm_pkg::ADDR_LSR, q);
    check("lsr", q, 16'h0060);
    rd(2'b01, dhm_pkg::ADDR_MCR, q);
    check("mcr", q, 16'h0000);
    wr(2'b11, dhm_pkg::ADDR_SPR, 8'h33);
    wr(2'b10, dhm_pkg::ADDR_SPR, 8'h5a);
    rd(2'b01, dhm_pkg::ADDR_SPR, q);
    check("spr a", q, 16'h0033);
    rd(2'b10, dhm_pkg::ADDR_SPR, q);
    check("spr b", q, 16'h005a);
    $display("strobe style done");
    mode_strap <= 1'b0;
    reset_pin <= 1'b1;
    repeat (10) @(posedge clk);
    wr(2'b01, dhm_pkg::ADDR_SPR, 8'h11);
    wr(2'b10, dhm_pkg::ADDR_SPR, 8'h22);
    rd(2'b01, dhm_pkg::ADDR_SPR, q);
    check("spr a", q, 16'h0011);
    rd(2'b10, dhm_pkg::ADDR_SPR, q);
    check("spr b", q, 16'h0022);
    pulse(1'b0);
    rd(2'b10, dhm_pkg::ADDR_SPR, q);
    check("spr b", q, {8'h00, dhm_pkg::SPR_RST});
    mode_strap <= 1'b1;
    reset_pin <= 1'b0;
    repeat (10) @(posedge clk);
    $display("direction style done");
    prescaler_strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    prescaler_strap <= 1'b1;
    rd(2'b01, dhm_pkg::ADDR_MCR, q);
    check("mcr a", q, 16'h0080);
    rd(2'b10, dhm_pkg::ADDR_MCR, q);
    check("mcr b", q, 16'h0080);
    cfg(8'h20);
    send_zero(16'h0010);
    $display("strap done");
    wr(2'b01, dhm_pkg::ADDR_DATA, 8'ha5);
    wr(2'b01, dhm_pkg::ADDR_DATA, 8'h3c);
    wr(2'b01, dhm_pkg::ADDR_DATA, 8'h81);
    rx_get(8'ha5);
    rx_get(8'h3c);
    rx_get(8'h81);
    $display("queue order done");
    conclude();
  end
  // The run needs about 2.2k cycles; over six times that is allowed before giving up.
  initial
  begin
    #150000;
    bad_count++;
    $display("MISMATCH watchdog expected end seen hang");
    conclude();
  end
endmodule // tb_dhm_host_port
`default_nettype wire
